// ===== hw/fsc_defs.vh
// Constants for the frontend system control register bank.
// Assumes inclusion by fsc_regs.v and its checker; definitions only.
`ifndef FSC_DEFS_VH
`define FSC_DEFS_VH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define FSC_IDX_SYSCTL 6'h00
`define FSC_IDX_IRQ_EN 6'h01
`define FSC_IDX_IRQ_FLAGS 6'h02
`define FSC_IDX_IRQ_CLR 6'h03
`define FSC_IDX_RESERVED_06 6'h06
`define FSC_IDX_TMR_A_STATE 6'h08
`define FSC_IDX_TMR_B_STATE 6'h09
`define FSC_IDX_TMR_C_STATE 6'h0A
`define FSC_IDX_RX_STATE 6'h13
`define FSC_IDX_FIELD_STATE 6'h1D
`define FSC_IDX_GAIN_READING 6'h1F
`define FSC_IDX_DEV_STATE 6'h24
`define FSC_IDX_LAST_PLAIN 6'h29
`define FSC_IDX_RM_EXT 6'h39
`define FSC_IDX_XCVR_SETUP 6'h04
`define FSC_IDX_PAD_SETUP 6'h05
`define FSC_IDX_PAD_OUT 6'h07
`define FSC_IDX_TMR_A_PRELOAD 6'h0B
`define FSC_IDX_TMR_B_PRELOAD 6'h0C
`define FSC_IDX_TMR_C_PRELOAD 6'h0D
`define FSC_IDX_TMR_A_SETUP 6'h0E
`define FSC_IDX_TMR_B_SETUP 6'h0F
`define FSC_IDX_TMR_C_SETUP 6'h10
`define FSC_IDX_RX_DELAY 6'h11
`define FSC_IDX_RX_CHECKSUM 6'h12
`define FSC_IDX_TX_UNDERSHOOT 6'h14
`define FSC_IDX_TX_OVERSHOOT 6'h15
`define FSC_IDX_TX_MOD_DATA 6'h16
`define FSC_IDX_TX_DELAY 6'h17
`define FSC_IDX_TX_SETUP 6'h18
`define FSC_IDX_TX_CHECKSUM 6'h19
`define FSC_IDX_SP_SETUP 6'h1A
`define FSC_IDX_SP_CARD 6'h1B
`define FSC_IDX_SP_READER 6'h1C
`define FSC_IDX_GAIN_SETUP 6'h1E
`define FSC_IDX_FIELD_TX_CTL 6'h20
`define FSC_IDX_FIELD_TX_CLK 6'h21
`define FSC_IDX_FIELD_RX_CTL 6'h22
`define FSC_IDX_LEVEL_DETECT 6'h23
`define FSC_IDX_THERMAL 6'h25
`define FSC_IDX_PROBE_OUT 6'h26
`define FSC_IDX_POWER_SETUP 6'h27
`define FSC_IDX_DISTURB 6'h28
`define FSC_IDX_ANTENNA 6'h29
// ----------------------------------------
// System control fields
// ----------------------------------------
`define FSC_CMD_LSB 0
`define FSC_CMD_MSB 2
`define FSC_SEND_BIT 3
`define FSC_PRS_BIT 5
`define FSC_CIPHER_BIT 6
`define FSC_SRST_BIT 8
`define FSC_TRIM_LSB 12
`define FSC_TRIM_MSB 19
`define FSC_SYSCTL_RW_MASK 32'h000FF06F
`define FSC_CMD_RESET 3'h1
// ----------------------------------------
// Command codes
// ----------------------------------------
`define FSC_CMD_HALT 3'h0
`define FSC_CMD_TRX 3'h3
`define FSC_CMD_HOLD 3'h4
`define FSC_CMD_ECHO 3'h5
`define FSC_CMD_PRS 3'h6
// ----------------------------------------
// Soft reset pulse length in cycles
// ----------------------------------------
`define FSC_SRST_CYCLES 4'h4
`endif

// ===== hw/fsc_regs.v
// Frontend system control register bank with APB slave and transceive sequencer.
// Assumes an APB master on pclk and frontend logic that takes the status inputs on pclk.
//
// Summary of operation
// - Writing one to bit 8 pulses a full device reset.
// - Bit 6 set enables the card cipher; clear bypasses it.
// - Bit 5 selects long pseudo-random sequence when one, short when zero.
// - Setting bit 3 triggers transmission per the transceive sequencer.
// - Bits 2:0 hold the command code, reset value 001.
// - Code 000 stops everything at once and returns to idle.
// - Code 011 starts a transceive cycle.
// - Transceive starts transmitting as initiator, otherwise enables receiver first.
// - Transceive never ends itself; only halt, codes 101 and 110, or a soft reset leave it.
// - Code 100 keeps the current command; other written bits apply.
// - Code 101 transmits and enables the receiver together.
// - Code 110 sends pseudo-random data endlessly with the selected length.
// - Bits 19:12 hold a gain trim added with stored offset to measured gain.
// - The trim is sign-magnitude, sign in the top bit, range -127..+127.
`timescale 1ns/1ps
`include "fsc_defs.vh"

module fsc_regs #(
	parameter GAIN_W = 10
) (
	input wire pclk, // APB clock
	input wire presetn, // Async reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [31:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error, unmapped address
	input wire initiator, // Initiator setting, same clock domain
	input wire tx_done, // End of transmission pulse
	input wire [GAIN_W-1:0] gain_measured, // Measured gain
	input wire [GAIN_W-1:0] gain_stored_offset, // Stored nonvolatile offset
	output reg soft_reset, // Full device reset pulse
	output reg cipher_enable, // Card cipher enable
	output reg prs_long, // Pseudo-random length select
	output reg tx_enable, // Transmitter active
	output reg rx_enable, // Receiver active
	output reg prs_tx, // Pseudo-random transmission active
	output reg [GAIN_W-1:0] gain_corrected // Measured gain plus offset plus trim
);
	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	localparam ST_IDLE = 3'h0;
	localparam ST_TX = 3'h1;
	localparam ST_RX = 3'h2;
	localparam ST_ECHO = 3'h3;
	localparam ST_PRS = 3'h4;

	// ----------------------------------------
	// Register access kinds
	// ----------------------------------------
	localparam KIND_NONE = 2'h0;
	localparam KIND_RW = 2'h1;
	localparam KIND_RO = 2'h2;

	reg [2:0] cmd_reg;
	reg send_reg;
	reg cipher_reg;
	reg prs_sel_reg;
	reg [7:0] trim_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [3:0] srst_cnt_reg;
	reg cmd_new_reg;
	wire [5:0] idx;
	wire wr_acc;
	wire rd_acc;
	wire mapped;
	wire [GAIN_W-1:0] trim_signed;
	wire [1:0] kind;
	wire addr_high_ok;
	wire addr_aligned;
	wire sysctl_wr;
	wire srst_wr;
	reg [31:0] store_mem [0:63];
	integer k;

	// Sign-magnitude byte to two's complement at gain width
	function [GAIN_W-1:0] sm_to_tc;
		input [7:0] sm;
		reg [GAIN_W-1:0] mag;
		begin
			mag = {{(GAIN_W-7){1'b0}}, sm[6:0]};
			sm_to_tc = sm[7] ? (~mag + {{(GAIN_W-1){1'b0}}, 1'b1}) : mag;
		end
	endfunction

	// Access kind of a register index; gaps and the reserved word are unmapped
	function [1:0] reg_kind;
		input [5:0] i;
		begin
			if (i == `FSC_IDX_SYSCTL) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_IRQ_EN) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_IRQ_FLAGS) begin
				reg_kind = KIND_RO;
			end else if (i == `FSC_IDX_IRQ_CLR) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_XCVR_SETUP) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_PAD_SETUP) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_PAD_OUT) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_TMR_A_STATE) begin
				reg_kind = KIND_RO;
			end else if (i == `FSC_IDX_TMR_B_STATE) begin
				reg_kind = KIND_RO;
			end else if (i == `FSC_IDX_TMR_C_STATE) begin
				reg_kind = KIND_RO;
			end else if (i == `FSC_IDX_TMR_A_PRELOAD) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_TMR_B_PRELOAD) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_TMR_C_PRELOAD) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_TMR_A_SETUP) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_TMR_B_SETUP) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_TMR_C_SETUP) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_RX_DELAY) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_RX_CHECKSUM) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_RX_STATE) begin
				reg_kind = KIND_RO;
			end else if (i == `FSC_IDX_TX_UNDERSHOOT) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_TX_OVERSHOOT) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_TX_MOD_DATA) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_TX_DELAY) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_TX_SETUP) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_TX_CHECKSUM) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_SP_SETUP) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_SP_CARD) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_SP_READER) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_FIELD_STATE) begin
				reg_kind = KIND_RO;
			end else if (i == `FSC_IDX_GAIN_SETUP) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_GAIN_READING) begin
				reg_kind = KIND_RO;
			end else if (i == `FSC_IDX_FIELD_TX_CTL) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_FIELD_TX_CLK) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_FIELD_RX_CTL) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_LEVEL_DETECT) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_DEV_STATE) begin
				reg_kind = KIND_RO;
			end else if (i == `FSC_IDX_THERMAL) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_PROBE_OUT) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_POWER_SETUP) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_DISTURB) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_ANTENNA) begin
				reg_kind = KIND_RW;
			end else if (i == `FSC_IDX_RM_EXT) begin
				reg_kind = KIND_RW;
			end else begin
				reg_kind = KIND_NONE;
			end
		end
	endfunction

	assign idx = paddr[7:2];
	assign wr_acc = psel & penable & pwrite & pready;
	assign rd_acc = psel & ~penable & ~pwrite;
	assign kind = reg_kind(idx);
	assign addr_high_ok = (paddr[31:8] == 24'h000000);
	assign addr_aligned = (paddr[1:0] == 2'h0);
	assign mapped = addr_high_ok && addr_aligned && (kind != KIND_NONE);
	assign sysctl_wr = wr_acc && !pslverr && (idx == `FSC_IDX_SYSCTL);
	assign srst_wr = sysctl_wr && pwdata[`FSC_SRST_BIT];
	assign trim_signed = sm_to_tc(trim_reg);

	// ----------------------------------------
	// APB slave: no wait states, answer in access phase
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			if (rd_acc) begin
				if (!mapped) begin
					prdata <= 32'h00000000;
				end else if (idx == `FSC_IDX_SYSCTL) begin
					prdata <= {12'h000, trim_reg, 5'h00, cipher_reg, prs_sel_reg, 1'b0,
						send_reg, cmd_reg};
				end else if (idx == `FSC_IDX_DEV_STATE) begin
					prdata <= {29'h00000000, state_reg};
				end else if (idx == `FSC_IDX_GAIN_READING) begin
					prdata <= {{(32-GAIN_W){1'b0}}, gain_corrected};
				end else if (kind == KIND_RW) begin
					prdata <= store_mem[idx];
				end else begin
					prdata <= 32'h00000000;
				end
			end
		end
	end

	// ----------------------------------------
	// System control register
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= `FSC_CMD_RESET;
			send_reg <= 1'b0;
			cipher_reg <= 1'b0;
			prs_sel_reg <= 1'b0;
			trim_reg <= 8'h00;
			cmd_new_reg <= 1'b0;
		end else if (srst_cnt_reg != 4'h0) begin
			cmd_reg <= `FSC_CMD_RESET;
			send_reg <= 1'b0;
			cipher_reg <= 1'b0;
			prs_sel_reg <= 1'b0;
			trim_reg <= 8'h00;
			cmd_new_reg <= 1'b0;
		end else begin
			cmd_new_reg <= 1'b0;
			if (sysctl_wr && !pwdata[`FSC_SRST_BIT]) begin
				send_reg <= pwdata[`FSC_SEND_BIT];
				cipher_reg <= pwdata[`FSC_CIPHER_BIT];
				prs_sel_reg <= pwdata[`FSC_PRS_BIT];
				trim_reg <= pwdata[`FSC_TRIM_MSB:`FSC_TRIM_LSB];
				if (pwdata[`FSC_CMD_MSB:`FSC_CMD_LSB] != `FSC_CMD_HOLD) begin
					cmd_reg <= pwdata[`FSC_CMD_MSB:`FSC_CMD_LSB];
					cmd_new_reg <= 1'b1;
				end
			end else if (tx_done) begin
				send_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Plain read/write words
	// ----------------------------------------
	// Setup words of the frontend; a soft reset clears them together with the control word
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (k = 0; k < 64; k = k + 1) begin
				store_mem[k] <= 32'h00000000;
			end
		end else if (srst_cnt_reg != 4'h0) begin
			for (k = 0; k < 64; k = k + 1) begin
				store_mem[k] <= 32'h00000000;
			end
		end else if (wr_acc && !pslverr && kind == KIND_RW && idx != `FSC_IDX_SYSCTL) begin
			store_mem[idx] <= pwdata;
		end
	end

	// ----------------------------------------
	// Soft reset pulse
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srst_cnt_reg <= 4'h0;
			soft_reset <= 1'b0;
		end else begin
			if (srst_wr) begin
				srst_cnt_reg <= `FSC_SRST_CYCLES;
			end else if (srst_cnt_reg != 4'h0) begin
				srst_cnt_reg <= srst_cnt_reg - 4'h1;
			end
			soft_reset <= srst_wr || (srst_cnt_reg > 4'h1);
		end
	end

	// ----------------------------------------
	// Transceive sequencer
	// ----------------------------------------
	always @* begin
		state_next = state_reg;
		if (cmd_new_reg) begin
			case (cmd_reg)
				`FSC_CMD_HALT: begin
					state_next = ST_IDLE;
				end
				`FSC_CMD_TRX: begin
					state_next = initiator ? ST_TX : ST_RX;
				end
				`FSC_CMD_ECHO: begin
					state_next = ST_ECHO;
				end
				`FSC_CMD_PRS: begin
					state_next = ST_PRS;
				end
				default: begin
					state_next = state_reg;
				end
			endcase
		end else begin
			case (state_reg)
				ST_TX: begin
					if (tx_done) begin
						state_next = ST_RX;
					end
				end
				ST_RX: begin
					if (send_reg) begin
						state_next = ST_TX;
					end
				end
				default: begin
					state_next = state_reg;
				end
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			tx_enable <= 1'b0;
			rx_enable <= 1'b0;
			prs_tx <= 1'b0;
			cipher_enable <= 1'b0;
			prs_long <= 1'b0;
			gain_corrected <= {GAIN_W{1'b0}};
		end else begin
			if (srst_cnt_reg != 4'h0) begin
				state_reg <= ST_IDLE;
			end else begin
				state_reg <= state_next;
			end
			tx_enable <= (state_reg == ST_TX) || (state_reg == ST_ECHO) || (state_reg == ST_PRS);
			rx_enable <= (state_reg == ST_RX) || (state_reg == ST_ECHO);
			prs_tx <= (state_reg == ST_PRS);
			cipher_enable <= cipher_reg;
			prs_long <= prs_sel_reg;
			gain_corrected <= gain_measured + gain_stored_offset + trim_signed;
		end
	end
endmodule

// ===== verification/fsc_props.sv
// Port-level checker for the system control bank.
// Assumes binding to every fsc_regs instance on one clock.
`timescale 1ns/1ps
`include "fsc_defs.vh"
module fsc_props #(
	parameter GAIN_W = 10
) (
	input wire pclk, // clock
	input wire presetn, // reset
	input wire psel, // select
	input wire penable, // enable
	input wire pwrite, // direction
	input wire [31:0] paddr, // address
	input wire [31:0] pwdata, // wdata
	input wire [31:0] prdata, // rdata
	input wire pready, // ready
	input wire pslverr, // error
	input wire initiator, // initiator
	input wire tx_done, // tx end
	input wire [GAIN_W-1:0] gain_measured, // gain
	input wire [GAIN_W-1:0] gain_stored_offset, // offset
	input wire soft_reset, // pulse
	input wire cipher_enable, // cipher
	input wire prs_long, // length
	input wire tx_enable, // tx
	input wire rx_enable, // rx
	input wire prs_tx, // prs
	input wire [GAIN_W-1:0] gain_corrected // sum
);
// ----------------------------------------
// Completed control writes
// ----------------------------------------
wire acc = psel && penable && pready && pwrite && paddr == 32'h0;
wire wr = acc && !pwdata[`FSC_SRST_BIT] && !soft_reset;
wire [2:0] cmd = pwdata[2:0];
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
srst_pulse_a: assert property (acc && pwdata[8] |-> ##[1:2] ($rose(soft_reset) ##0 soft_reset[*4] ##1 !soft_reset))
	else $error("bad reset pulse");
ctl_copy_a: assert property (wr |-> ##2 cipher_enable == $past(pwdata[6], 2) && prs_long == $past(pwdata[5], 2))
	else $error("bad control copy");
halt_idle_a: assert property (wr && cmd == `FSC_CMD_HALT |-> ##3 !tx_enable && !rx_enable && !prs_tx)
	else $error("halt not idle");
init_dir_a: assert property (wr && cmd == `FSC_CMD_TRX && !pwdata[3] |-> ##3 tx_enable == $past(initiator, 3) && rx_enable != $past(initiator, 3))
	else $error("bad transceive start");
hold_keep_a: assert property (wr && cmd == `FSC_CMD_HOLD && !pwdata[3] && !tx_enable |-> ##3 !tx_enable && rx_enable == $past(rx_enable, 3))
	else $error("hold changed state");
echo_both_a: assert property (wr && cmd == `FSC_CMD_ECHO |-> ##3 tx_enable && rx_enable)
	else $error("echo not both");
prs_run_a: assert property (wr && cmd == `FSC_CMD_PRS |-> ##3 prs_tx[*4])
	else $error("prs not running");
trx_stays_a: assert property (rx_enable && !psel && !$past(psel) && !$past(psel, 2) |=> rx_enable)
	else $error("receive ended alone");
endmodule
bind fsc_regs fsc_props #(.GAIN_W(GAIN_W)) props_i (.*);

// ===== verification/testbench.sv
// Self-checking bench for the system control bank.
// Assumes fsc_props is bound to the design.
`timescale 1ns/1ps
module testbench;
logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, initiator = 1'h1, tx_done = 1'h0, err;
logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
logic [9:0] gain_measured = 10'h005, gain_stored_offset = 10'h003, gain_corrected;
logic pready, pslverr, soft_reset, cipher_enable, prs_long, tx_enable, rx_enable, prs_tx;
integer failures = 0, total_checks = 0, srst_n = 0;
fsc_regs #(.GAIN_W(10)) dut (.*);
initial begin
	forever #10 pclk = ~pclk;
end
always @(posedge pclk) if (soft_reset === 1'h1) srst_n <= srst_n + 1;
// ----------------------------------------
// Bus and compare tasks
// ----------------------------------------
task chk(input logic [31:0] s, input logic [31:0] e);
	total_checks = total_checks + 1;
	if (s !== e) begin
		failures = failures + 1;
		$display("Error %0t: got %h exp %h", $time, s, e);
	end
endtask
task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
	psel <= 1'h1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'h1;
	@(posedge pclk);
	while (pready !== 1'h1) begin
		@(posedge pclk);
	end
	rd = prdata;
	err = pslverr;
	psel <= 1'h0;
	penable <= 1'h0;
	@(posedge pclk);
endtask
task cmd(input logic [31:0] d, input logic [2:0] e);
	apb(1'h1, 32'h0, d);
	repeat (3) @(posedge pclk);
	chk({29'h0, tx_enable, rx_enable, prs_tx}, {29'h0, e});
endtask
task close_out;
	$display("checks %0d failures %0d", total_checks, failures);
	if (failures == 0 && total_checks > 0) begin
		$display("RESULT: PASS");
	end else begin
		$display("RESULT: FAIL");
	end
	$finish;
endtask
initial begin
	#10000;
	failures = failures + 1;
	close_out;
end
initial begin
	repeat (2) @(posedge pclk);
	presetn <= 1'h1;
	@(posedge pclk);
	apb(1'h0, 32'h0, 32'h0);
	chk(rd, 32'h1);
	apb(1'h1, 32'h0, 32'hF00FF0F4);
	repeat (3) @(posedge pclk);
	apb(1'h0, 32'h0, 32'h0);
	chk(rd, 32'h000FF061);
	chk({30'h0, cipher_enable, prs_long}, 32'h3);
	chk({22'h0, gain_corrected}, 32'h389);
	apb(1'h1, 32'h0, 32'h0007F064);
	repeat (3) @(posedge pclk);
	chk({22'h0, gain_corrected}, 32'h087);
	cmd(32'h3, 3'h4);
	tx_done <= 1'h1;
	@(posedge pclk);
	tx_done <= 1'h0;
	repeat (23) @(posedge pclk);
	chk({29'h0, tx_enable, rx_enable, prs_tx}, 32'h2);
	apb(1'h0, 32'h90, 32'h0);
	chk(rd, 32'h2);
	cmd(32'h0, 3'h0);
	initiator <= 1'h0;
	cmd(32'h3, 3'h2);
	cmd(32'hC, 3'h4);
	cmd(32'h0, 3'h0);
	cmd(32'h5, 3'h6);
	cmd(32'h26, 3'h5);
	chk({31'h0, prs_long}, 32'h1);
	apb(1'h1, 32'h0, 32'h100);
	repeat (8) @(posedge pclk);
	chk(srst_n, 32'h4);
	apb(1'h0, 32'h0, 32'h0);
	chk(rd, 32'h1);
	apb(1'h0, 32'h18, 32'h0);
	chk({31'h0, err}, 32'h1);
	chk(rd, 32'h0);
	close_out;
end
endmodule
